// [hw/pmst_pkg.sv]
/*
 Shared constants, field positions and carrier types of the power-up
 memory self-test block. Assumes a 32-bit classic Wishbone register bus
 and 16-bit synchronous ROM and RAM devices.
*/
package pmst_pkg;
	localparam int PMST_DW     = 16;
	localparam int PMST_RAM_AW = 10;
	localparam int PMST_ROM_AW = 8;
	localparam int PMST_WB_AW  = 5;
	localparam int PMST_MSGS   = 20;

	// Register byte offsets
	localparam logic [4:0] REG_CTRL     = 5'h00;
	localparam logic [4:0] REG_TESTNUM  = 5'h04;
	localparam logic [4:0] REG_STATUS   = 5'h08;
	localparam logic [4:0] REG_RESULT   = 5'h0C;
	localparam logic [4:0] REG_DET_ADDR = 5'h10;
	localparam logic [4:0] REG_DET_ACT  = 5'h14;
	localparam logic [4:0] REG_DET_EXP  = 5'h18;
	localparam logic [4:0] REG_LEDS     = 5'h1C;

	// Control fields
	localparam int CB_RUN    = 0;
	localparam int CB_SCOPE  = 1;
	localparam int CB_LOOP   = 4;
	localparam int CB_STOP_ERR = 5;
	localparam int CB_VERB   = 6;
	localparam int CB_PUP    = 7;
	localparam logic [7:0] CTRL_RST = 8'h80;

	// Status fields
	localparam int SB_BUSY = 0;
	localparam int SB_OK   = 1;
	localparam int SB_FAIL = 2;
	localparam int SB_BYP  = 3;
	localparam int SB_MORE = 4;
	localparam int SB_SRQ  = 5;

	// Result fields
	localparam int RB_TEST = 8;
	localparam int RB_FAIL = 12;
	localparam int RB_MORE = 13;
	localparam logic [1:0] RES_PASSED   = 2'h0;
	localparam logic [1:0] RES_FAILED   = 2'h1;
	localparam logic [1:0] RES_BYPASSED = 2'h2;

	typedef enum logic [2:0] {
		SC_ALL = 3'h0,
		SC_MPU = 3'h1,
		SC_PANEL = 3'h2,
		SC_ACQ = 3'h3,
		SC_NUM = 3'h4
	} pmst_scope_e;

	// Test codes as shown on the diagnostic LEDs
	localparam logic [3:0] TC_NONE     = 4'h0;
	localparam logic [3:0] TC_ROM_LOC0 = 4'h2;
	localparam logic [3:0] TC_ROM_SUM0 = 4'h6;
	localparam logic [3:0] TC_ROM_SUM3 = 4'h9;
	localparam logic [3:0] TC_RAM_DATA = 4'hA;
	localparam logic [3:0] TC_RAM_ADDR = 4'hB;
	localparam logic [15:0] MPU_MASK   = 16'h0FFC;

	localparam logic [1:0] LS_IDLE = 2'h0;
	localparam logic [1:0] LS_RUN  = 2'h1;
	localparam logic [1:0] LS_ERR  = 2'h2;

	localparam logic [15:0] ROM_LOC_BASE = 16'h0000;
	localparam logic [15:0] WALK_FIRST   = 16'h0001;
	localparam logic [4:0][15:0] ADDR_PAT = {16'hAAAA, 16'h5555, 16'h0F0F,
		16'hCCCC, 16'hAAAA};
	localparam logic [2:0] PH_LAST  = 3'h5;
	localparam logic [3:0] OPT_LAST = 4'h9;
	localparam logic [3:0] OPT_ALL  = 4'hF;
	localparam logic [3:0] OPT_FIRST = 4'h1;
	localparam logic [1:0] BOOT_CYC = 2'h3;

	typedef struct packed {
		logic                  cyc;
		logic                  stb;
		logic                  we;
		logic [PMST_WB_AW-1:0] adr;
		logic [3:0]            sel;
		logic [31:0]           dat;
	} pmst_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pmst_wb_rsp_s;

	typedef struct packed {
		logic                   re;
		logic                   we;
		logic [PMST_RAM_AW-1:0] addr;
		logic [PMST_DW-1:0]     wdata;
	} pmst_ram_req_s;
endpackage

// [hw/pmst_rom_check.sv]
/*
 One ROM check: placement code in the last word, or a wrapping sum of
 words 1..last against the reference in word 0. Assumes a synchronous
 ROM returning data the cycle after rom_re_o.
*/
`timescale 1ns/1ps
module pmst_rom_check #(
	parameter int ROM_AW = pmst_pkg::PMST_ROM_AW
) (
	// Clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         reset_n_i,
	// Command
	input  wire logic                         start_i,
	input  wire logic [1:0]                   rom_idx_i,
	input  wire logic                         sum_mode_i,
	// ROM port
	output logic      [1:0]                   rom_sel_o,
	output logic      [ROM_AW-1:0]            rom_addr_o,
	output logic                              rom_re_o,
	input  wire logic [pmst_pkg::PMST_DW-1:0] rom_data_i,
	// Result
	output logic                              done_o,
	output logic                              fail_o,
	output logic      [ROM_AW-1:0]            fail_addr_o,
	output logic      [pmst_pkg::PMST_DW-1:0] fail_act_o,
	output logic      [pmst_pkg::PMST_DW-1:0] fail_exp_o
);
	import pmst_pkg::*;

	localparam logic [ROM_AW-1:0] LAST = '1;
	localparam logic [ROM_AW-1:0] HDR  = '0;

	logic               iss_r;
	logic               dv_r;
	logic               mode_r;
	logic [ROM_AW-1:0]  addr_r;
	logic [ROM_AW-1:0]  da_r;
	logic [PMST_DW-1:0] ref_r;
	logic [PMST_DW-1:0] sum_r;
	logic [PMST_DW-1:0] sum_nxt;
	logic [PMST_DW-1:0] loc_exp;

	assign rom_addr_o = addr_r;
	assign rom_re_o   = iss_r;
	// Carries past the reference width are dropped
	assign sum_nxt = sum_r + rom_data_i;
	assign loc_exp = ROM_LOC_BASE + {{(PMST_DW-2){1'b0}}, rom_sel_o};

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			iss_r     <= 1'b0;
			mode_r    <= 1'b0;
			rom_sel_o <= 2'h0;
			addr_r    <= '0;
		end else if (start_i) begin
			iss_r     <= 1'b1;
			mode_r    <= sum_mode_i;
			rom_sel_o <= rom_idx_i;
			addr_r    <= sum_mode_i ? HDR : LAST;
		end else if (iss_r) begin
			if (addr_r == LAST) begin
				iss_r <= 1'b0;
			end else begin
				addr_r <= addr_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dv_r        <= 1'b0;
			da_r        <= '0;
			ref_r       <= '0;
			sum_r       <= '0;
			done_o      <= 1'b0;
			fail_o      <= 1'b0;
			fail_addr_o <= '0;
			fail_act_o  <= '0;
			fail_exp_o  <= '0;
		end else begin
			dv_r   <= iss_r;
			da_r   <= addr_r;
			done_o <= 1'b0;
			if (start_i) begin
				sum_r  <= '0;
				fail_o <= 1'b0;
			end else if (dv_r) begin
				if (mode_r && da_r == HDR) begin
					ref_r <= rom_data_i;
				end else if (mode_r) begin
					sum_r <= sum_nxt;
				end
				if (da_r == LAST) begin
					done_o      <= 1'b1;
					fail_addr_o <= da_r;
					fail_act_o  <= mode_r ? sum_nxt : rom_data_i;
					fail_exp_o  <= mode_r ? ref_r : loc_exp;
					fail_o      <= mode_r ? (sum_nxt != ref_r) : (rom_data_i != loc_exp);
				end
			end
		end
	end
endmodule

// [hw/pmst_self_test.sv]
/*
 Power-up and on-demand memory self-test sequencer: ROM placement and
 checksum, RAM walking-ones and address march, diagnostic LEDs, result
 registers and a display message store. Assumes synchronous ROM/RAM on
 clk_sys_i with one cycle read latency, and DIP switches from pins.
*/
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module pmst_self_test #(
	parameter int ROM_AW   = pmst_pkg::PMST_ROM_AW,
	parameter int OPT_STEP = 1000
) (
	// Clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         reset_n_i,
	// Register bus
	input  wire pmst_pkg::pmst_wb_req_s       wb_i,
	output pmst_pkg::pmst_wb_rsp_s            wb_o,
	// ROM port
	output logic      [1:0]                   rom_sel_o,
	output logic      [ROM_AW-1:0]            rom_addr_o,
	output logic                              rom_re_o,
	input  wire logic [pmst_pkg::PMST_DW-1:0] rom_data_i,
	// RAM port
	output pmst_pkg::pmst_ram_req_s           ram_o,
	input  wire logic [pmst_pkg::PMST_DW-1:0] ram_rdata_i,
	// Switches
	input  wire logic                         dip_pup_i,
	input  wire logic                         dip_kloop_i,
	// Indicators and display
	output logic      [7:0]                   diagnostic_result_query_led_o,
	output logic      [3:0]                   opt_led_o,
	output logic                              srq_o,
	input  wire logic [4:0]                   disp_idx_i,
	output logic      [7:0]                   disp_msg_o
);
	import pmst_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_BOOT  = 4'h1,
		ST_SEL   = 4'h3,
		ST_ROM   = 4'h2,
		ST_DW    = 4'h6,
		ST_DR    = 4'h7,
		ST_DC    = 4'h5,
		ST_AFILL = 4'h4,
		ST_ARD   = 4'hC,
		ST_ACMP  = 4'hD,
		ST_PROBE = 4'hF,
		ST_DONE  = 4'hE
	} pmst_state_e;

	localparam logic [PMST_RAM_AW-1:0] RAM_LAST = '1;
	localparam logic [PMST_RAM_AW-1:0] RAM_BASE = '0;
	localparam logic [15:0] OPT_STEP_C = 16'(OPT_STEP - 1);

	function automatic logic [3:0] next_code(input logic [15:0] m, input logic [3:0] c);
		logic [3:0] r;
		r = TC_NONE;
		for (int i = 15; i > 0; i--) begin
			if (m[i] && 4'(i) > c) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	pmst_state_e          state_r;
	logic [1:0]           sync1_r;
	logic [1:0]           sync2_r;
	logic [1:0]           boot_r;
	logic [7:0]           ctrl_r;
	logic [7:0]           pend_ctrl_r;
	logic [5:0]           num_r;
	logic [5:0]           pend_num_r;
	logic                 pend_r;
	logic                 stop_r;
	logic                 kern_r;
	logic [15:0]          mask_r;
	logic [3:0]           cur_r;
	logic [15:0]          walk_r;
	logic [2:0]           ph_r;
	logic [PMST_RAM_AW-1:0] addr_r;
	logic                 tog_r;
	logic                 ok_r;
	logic                 byp_r;
	logic                 srq_r;
	logic                 res_fail_r;
	logic                 more_r;
	logic [3:0]           res_test_r;
	logic [15:0]          det_addr_r;
	logic [15:0]          det_act_r;
	logic [15:0]          det_exp_r;
	logic [1:0]           led_stat_r;
	logic [3:0]           opt_r;
	logic [15:0]          div_r;
	logic                 ack_r;
	logic [31:0]          rdat_r;
	logic [7:0]           msg_mem [PMST_MSGS];
	logic [4:0]           msg_wp_r;
	logic [4:0]           msg_cnt_r;
	logic                 rom_go;
	logic                 rom_done;
	logic                 rom_fail;
	logic [ROM_AW-1:0]    rom_faddr;
	logic [15:0]          rom_fact;
	logic [15:0]          rom_fexp;
	logic [3:0]           nc;
	logic                 loop_eff;
	logic                 rep;
	logic                 ram_bad;
	logic                 fail_ev;
	logic [15:0]          f_addr;
	logic [15:0]          f_act;
	logic [15:0]          f_exp;
	logic                 acc;
	logic                 wr;
	logic                 apply;
	logic                 start;
	logic [15:0]          sel_mask;

	assign acc      = wb_i.cyc & wb_i.stb;
	assign wr       = acc & wb_i.we & ack_r & wb_i.sel[0];
	assign nc       = next_code(mask_r, cur_r);
	assign loop_eff = kern_r ? sync2_r[1] : ctrl_r[CB_LOOP];
	assign rep      = loop_eff | (!kern_r & ctrl_r[CB_STOP_ERR]);
	assign apply    = state_r == ST_IDLE && pend_r;
	assign start    = apply && pend_ctrl_r[CB_RUN];
	assign rom_go   = state_r == ST_SEL && nc != TC_NONE && nc < TC_RAM_DATA;
	assign ram_bad  = ram_rdata_i != (state_r == ST_DC ? walk_r : ADDR_PAT[ph_r - 3'h1]);

	// Test set chosen by the held command
	always_comb begin
		sel_mask = 16'h0000;
		case (pmst_scope_e'(pend_ctrl_r[CB_SCOPE +: 3]))
			SC_ALL, SC_MPU: sel_mask = MPU_MASK;
			// Numbers past 15 must not alias onto a low test
			SC_NUM: sel_mask = (pend_num_r[5:4] == 2'h0) ?
				MPU_MASK & (16'h0001 << pend_num_r[3:0]) : 16'h0000;
			default: sel_mask = 16'h0000; // Those groups live elsewhere
		endcase
	end

	// Failure detection for the running test
	always_comb begin
		fail_ev = 1'b0;
		f_addr  = 16'h0000;
		f_act   = ram_rdata_i;
		f_exp   = walk_r;
		case (state_r)
			ST_ROM: begin
				fail_ev = rom_done & rom_fail;
				f_addr  = 16'(rom_faddr);
				f_act   = rom_fact;
				f_exp   = rom_fexp;
			end
			ST_DC: fail_ev = ram_bad;
			ST_ACMP: begin
				fail_ev = ram_bad;
				f_addr  = 16'(addr_r);
				f_exp   = ADDR_PAT[ph_r - 3'h1];
			end
			default: fail_ev = 1'b0;
		endcase
	end

	// RAM request decoded from state registers, plus the read data compare (ram_bad) in ST_ACMP
	always_comb begin
		ram_o = '0;
		case (state_r)
			ST_DW: begin
				ram_o.we    = 1'b1;
				ram_o.addr  = RAM_BASE;
				ram_o.wdata = walk_r;
			end
			ST_DR: begin
				ram_o.re   = 1'b1;
				ram_o.addr = RAM_BASE;
			end
			ST_AFILL: begin
				ram_o.we    = 1'b1;
				ram_o.addr  = addr_r;
				ram_o.wdata = ADDR_PAT[0];
			end
			ST_ARD: begin
				ram_o.re   = 1'b1;
				ram_o.addr = addr_r;
			end
			ST_ACMP: begin
				ram_o.we    = ph_r != PH_LAST && !ram_bad;
				ram_o.addr  = addr_r;
				ram_o.wdata = ADDR_PAT[ph_r];
			end
			ST_PROBE: begin
				if (cur_r == TC_RAM_DATA) begin
					ram_o.re   = 1'b1;
					ram_o.addr = PMST_RAM_AW'(walk_r);
				end else begin
					ram_o.we    = tog_r;
					ram_o.re    = !tog_r;
					ram_o.addr  = addr_r;
					ram_o.wdata = det_exp_r;
				end
			end
			default: ram_o = '0;
		endcase
	end

	pmst_rom_check #(
		.ROM_AW(ROM_AW)
	) u_rom (
		.clk_sys_i  (clk_sys_i),
		.reset_n_i  (reset_n_i),
		.start_i    (rom_go),
		.rom_idx_i  (nc[1:0]),
		.sum_mode_i (nc >= TC_ROM_SUM0),
		.rom_sel_o  (rom_sel_o),
		.rom_addr_o (rom_addr_o),
		.rom_re_o   (rom_re_o),
		.rom_data_i (rom_data_i),
		.done_o     (rom_done),
		.fail_o     (rom_fail),
		.fail_addr_o(rom_faddr),
		.fail_act_o (rom_fact),
		.fail_exp_o (rom_fexp)
	);

	// Switch synchronisers
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end else begin
			sync1_r <= {dip_kloop_i, dip_pup_i};
			sync2_r <= sync1_r;
		end
	end

	// Sequencer
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= ST_BOOT;
			boot_r  <= 2'h0;
			kern_r  <= 1'b0;
			mask_r  <= 16'h0000;
			cur_r   <= TC_NONE;
			walk_r  <= WALK_FIRST;
			ph_r    <= 3'h0;
			addr_r  <= '0;
			tog_r   <= 1'b0;
		end else begin
			tog_r <= !tog_r;
			case (state_r)
				ST_BOOT: begin
					boot_r <= boot_r + 2'h1;
					if (boot_r == BOOT_CYC) begin
						kern_r  <= 1'b1;
						mask_r  <= MPU_MASK;
						cur_r   <= TC_NONE;
						state_r <= (ctrl_r[CB_PUP] && sync2_r[0]) ? ST_SEL : ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (start) begin
						kern_r  <= 1'b0;
						mask_r  <= sel_mask;
						cur_r   <= TC_NONE;
						state_r <= ST_SEL;
					end
				end
				ST_SEL: begin
					if (nc == TC_NONE) begin
						cur_r <= TC_NONE;
						// Finish a pass, repeat while rep holds, unless any register write arrived or a failure ends a run that is not looping
						if (!rep || stop_r || (!loop_eff && res_fail_r)) begin
							state_r <= ST_DONE;
						end
					end else begin
						cur_r  <= nc;
						walk_r <= WALK_FIRST;
						addr_r <= '0;
						ph_r   <= 3'h0;
						if (nc == TC_RAM_DATA) begin
							state_r <= ST_DW;
						end else if (nc == TC_RAM_ADDR) begin
							state_r <= ST_AFILL;
						end else begin
							state_r <= ST_ROM;
						end
					end
				end
				ST_ROM: begin
					if (rom_done) begin
						state_r <= (fail_ev && !loop_eff) ? ST_DONE : ST_SEL;
					end
				end
				ST_DW: state_r <= ST_DR;
				ST_DR: state_r <= ST_DC;
				ST_DC: begin
					if (fail_ev) begin
						state_r <= loop_eff ? ST_SEL : ST_PROBE;
					end else if (walk_r[PMST_DW-1]) begin
						state_r <= ST_SEL;
					end else begin
						walk_r  <= walk_r << 1;
						state_r <= ST_DW;
					end
				end
				ST_AFILL: begin
					addr_r <= addr_r + 1'b1;
					if (addr_r == RAM_LAST) begin
						ph_r    <= 3'h1;
						state_r <= ST_ARD;
					end
				end
				ST_ARD: state_r <= ST_ACMP;
				ST_ACMP: begin
					if (fail_ev) begin
						state_r <= loop_eff ? ST_SEL : ST_PROBE;
					end else begin
						addr_r  <= addr_r + 1'b1;
						state_r <= ST_ARD;
						if (addr_r == RAM_LAST) begin
							ph_r <= ph_r + 3'h1;
							if (ph_r == PH_LAST) begin
								state_r <= ST_SEL;
							end
						end
					end
				end
				ST_PROBE: begin
					// Fault held on the pins until the host writes CTRL or TESTNUM
					if (pend_r) begin
						state_r <= ST_DONE;
					end
				end
				ST_DONE: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Command holding and control register
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r      <= CTRL_RST;
			pend_ctrl_r <= CTRL_RST;
			num_r       <= 6'h00;
			pend_num_r  <= 6'h00;
			pend_r      <= 1'b0;
			stop_r      <= 1'b0;
		end else begin
			if (apply) begin
				ctrl_r              <= pend_ctrl_r;
				num_r               <= pend_num_r;
				pend_ctrl_r[CB_RUN] <= 1'b0;
				pend_r              <= 1'b0;
			end
			if (state_r == ST_IDLE || state_r == ST_BOOT) begin
				stop_r <= 1'b0;
			end
			if (wr && wb_i.adr == REG_CTRL) begin
				pend_ctrl_r <= wb_i.dat[7:0];
				pend_r      <= 1'b1;
			end
			if (wr && wb_i.adr == REG_TESTNUM) begin
				pend_num_r <= wb_i.dat[5:0];
				pend_r     <= 1'b1;
			end
			if (wr && state_r != ST_IDLE) begin
				stop_r <= 1'b1;
			end
		end
	end

	// Result capture and run events
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ok_r       <= 1'b0;
			byp_r      <= 1'b0;
			srq_r      <= 1'b0;
			res_fail_r <= 1'b0;
			more_r     <= 1'b0;
			res_test_r <= TC_NONE;
			det_addr_r <= 16'h0000;
			det_act_r  <= 16'h0000;
			det_exp_r  <= 16'h0000;
			led_stat_r <= LS_IDLE;
		end else begin
			if (wr && wb_i.adr == REG_STATUS) begin
				ok_r  <= ok_r & !wb_i.dat[SB_OK];
				byp_r <= byp_r & !wb_i.dat[SB_BYP];
				srq_r <= srq_r & !wb_i.dat[SB_SRQ];
			end
			if (start || (state_r == ST_BOOT && boot_r == BOOT_CYC)) begin
				res_fail_r <= 1'b0;
				more_r     <= 1'b0;
				ok_r       <= 1'b0;
			end
			if (state_r == ST_BOOT && boot_r == BOOT_CYC && !(ctrl_r[CB_PUP] && sync2_r[0])) begin
				byp_r <= 1'b1;
				srq_r <= 1'b1;
			end
			if (state_r == ST_SEL && nc != TC_NONE) begin
				led_stat_r <= LS_RUN;
				if (!res_fail_r) begin
					res_test_r <= nc;
				end
			end
			if (fail_ev) begin
				led_stat_r <= LS_ERR;
				if (res_fail_r) begin
					more_r <= 1'b1;
				end else begin
					res_fail_r <= 1'b1;
					det_addr_r <= f_addr;
					det_act_r  <= f_act;
					det_exp_r  <= f_exp;
				end
			end
			if (state_r == ST_DONE) begin
				if (res_fail_r) begin
					srq_r <= 1'b1;
				end else begin
					ok_r       <= 1'b1;
					led_stat_r <= LS_IDLE;
				end
			end
		end
	end

	// Option board count and message store
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			opt_r     <= 4'h0;
			div_r     <= 16'h0000;
			msg_wp_r  <= 5'h00;
			msg_cnt_r <= 5'h00;
		end else begin
			div_r <= (div_r == OPT_STEP_C) ? 16'h0000 : div_r + 16'h0001;
			if (state_r == ST_BOOT) begin
				opt_r <= OPT_FIRST;
			end else if (kern_r && state_r != ST_IDLE && div_r == OPT_STEP_C && opt_r < OPT_LAST) begin
				opt_r <= opt_r + 4'h1;
			end
			if (kern_r && state_r == ST_DONE && !res_fail_r) begin
				opt_r <= OPT_ALL;
			end
			if (state_r == ST_DONE) begin
				msg_wp_r <= (msg_wp_r == 5'(PMST_MSGS - 1)) ? 5'h00 : msg_wp_r + 5'h01;
				if (msg_cnt_r != 5'(PMST_MSGS)) begin
					msg_cnt_r <= msg_cnt_r + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (state_r == ST_DONE) begin
			msg_mem[msg_wp_r] <= {res_fail_r, more_r, 2'h0, res_test_r};
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			disp_msg_o <= 8'h00;
		end else begin
			disp_msg_o <= (disp_idx_i < msg_cnt_r) ? msg_mem[disp_idx_i] : 8'h00;
		end
	end

	// Wishbone slave, one wait state
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			ack_r  <= acc & !ack_r;
			rdat_r <= 32'h0000_0000;
			if (acc && !ack_r) begin
				case (wb_i.adr)
					REG_CTRL:    rdat_r[7:0] <= {ctrl_r[7:1], 1'b0};
					REG_TESTNUM: rdat_r[5:0] <= num_r;
					REG_STATUS:  rdat_r[5:0] <= {srq_r, more_r, byp_r, res_fail_r, ok_r,
						state_r != ST_IDLE};
					REG_RESULT: begin
						rdat_r[1:0] <= byp_r ? RES_BYPASSED :
							(res_fail_r ? RES_FAILED : RES_PASSED);
						if (ctrl_r[CB_VERB]) begin
							rdat_r[RB_TEST +: 4] <= res_test_r;
							rdat_r[RB_FAIL]      <= res_fail_r;
							rdat_r[RB_MORE]      <= more_r;
						end
					end
					REG_DET_ADDR: rdat_r[15:0] <= ctrl_r[CB_VERB] ? det_addr_r : 16'h0000;
					REG_DET_ACT:  rdat_r[15:0] <= ctrl_r[CB_VERB] ? det_act_r : 16'h0000;
					REG_DET_EXP:  rdat_r[15:0] <= ctrl_r[CB_VERB] ? det_exp_r : 16'h0000;
					REG_LEDS:     rdat_r[11:0] <= {opt_r, diagnostic_result_query_led_o};
					default:      rdat_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_o.ack   = ack_r;
	assign wb_o.dat   = rdat_r;
	assign srq_o      = srq_r;
	assign opt_led_o  = opt_r;
	assign diagnostic_result_query_led_o = {led_stat_r, 2'h0, cur_r == TC_NONE ? res_test_r : cur_r};
endmodule

// [sim/pmst_self_test_properties.sv]
/* Port assertions for the self-test block.
 Bound to every pmst_self_test instance. */
`timescale 1ns/1ps
module pmst_self_test_properties (
	// Watched ports
	input wire logic                    clk_sys_i,
	input wire logic                    reset_n_i,
	input wire pmst_pkg::pmst_wb_req_s  wb_i,
	input wire pmst_pkg::pmst_wb_rsp_s  wb_o,
	input wire pmst_pkg::pmst_ram_req_s ram_o,
	input wire logic [7:0]              diagnostic_result_query_led_o,
	input wire logic [3:0]              opt_led_o,
	input wire logic                    srq_o
);
	import pmst_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	sequence req_q; wb_i.cyc && wb_i.stb && !wb_o.ack; endsequence
	sequence ack_q; wb_o.ack ##1 !wb_o.ack; endsequence
	AST_ACK_LAT: assert property (req_q |=> ack_q)
		else $error("late bus answer");
	AST_ACK_IDLE: assert property (!(wb_i.cyc && wb_i.stb) |=> !wb_o.ack)
		else $error("unasked bus answer");
	AST_RAM_PAT: assert property (ram_o.we |-> $onehot(ram_o.wdata) || ram_o.wdata inside
		{16'hAAAA, 16'hCCCC, 16'h0F0F, 16'h5555})
		else $error("bad ram pattern");
	AST_DATA_BASE: assert property (diagnostic_result_query_led_o == {LS_RUN, 2'b00, TC_RAM_DATA} && ram_o.we
		|-> ram_o.addr == '0)
		else $error("data test off base");
	AST_FAULT_CODE: assert property ($rose(diagnostic_result_query_led_o[7]) |-> diagnostic_result_query_led_o[6] == 1'b0
		&& diagnostic_result_query_led_o[3:0] != TC_NONE)
		else $error("fault without code");
	AST_OPT_RANGE: assert property (opt_led_o <= OPT_LAST || opt_led_o == OPT_ALL)
		else $error("option led out of range");
	AST_OPT_STEP: assert property ($changed(opt_led_o) && opt_led_o != OPT_ALL
		|-> opt_led_o == $past(opt_led_o) + 4'h1)
		else $error("option led skipped");
	AST_SRQ_CAUSE: assert property ($rose(srq_o) |-> diagnostic_result_query_led_o[7:6] != LS_RUN)
		else $error("request while running");
endmodule
bind pmst_self_test pmst_self_test_properties chk_inst (.clk_sys_i(clk_sys_i),
	.reset_n_i(reset_n_i), .wb_i(wb_i), .wb_o(wb_o), .ram_o(ram_o),
	.diagnostic_result_query_led_o(diagnostic_result_query_led_o), .opt_led_o(opt_led_o), .srq_o(srq_o));

// [sim/pmst_mem_model.sv]
/* ROM and RAM model, one cycle read.
 Assumes the self-test clock; fault_i sticks RAM bit 3 low. */
`timescale 1ns/1ps
module pmst_mem_model #(
	parameter int AW = 4
) (
	// Clock
	input  wire logic                    clk_sys_i,
	// ROM side
	input  wire logic [1:0]              rom_sel_i,
	input  wire logic [AW-1:0]           rom_addr_i,
	input  wire logic                    rom_re_i,
	output logic      [15:0]             rom_data_o,
	// RAM side
	input  wire pmst_pkg::pmst_ram_req_s ram_i,
	input  wire logic                    fault_i,
	output logic      [15:0]             ram_rdata_o
);
	import pmst_pkg::*;
	logic [15:0] rom [4][2**AW];
	logic [15:0] ram [1024];
	initial begin
		for (int i = 0; i < 4; i++) begin
			rom[i][0] = '0;
			for (int a = 1; a < 2**AW; a++) begin
				rom[i][a] = (a == 2**AW - 1) ? 16'(i) : 16'(a * 16'h1357 + i);
				rom[i][0] = rom[i][0] + rom[i][a];
			end
		end
	end
	// Idle outputs toggle so stale data never looks valid
	always @(posedge clk_sys_i) begin
		rom_data_o <= rom_re_i ? rom[rom_sel_i][rom_addr_i] : ~rom_data_o;
		ram_rdata_o <= ram_i.re ? ram[ram_i.addr] & ~{12'h0, fault_i, 3'h0} : ~ram_rdata_o;
		if (ram_i.we) ram[ram_i.addr] <= ram_i.wdata;
	end
endmodule

// [sim/pmst_self_test_bench.sv]
/* Self-checking bench for pmst_self_test.
 Uses pmst_mem_model as ROM and RAM. */
`timescale 1ns/1ps
module pmst_self_test_bench;
	import pmst_pkg::*;
	logic clk_sys_i = 0, reset_n_i = 0, rom_re, srq, pup = 1, fault = 0, kloop = 0;
	logic [4:0] disp_idx = 5'h00;
	pmst_wb_req_s wb_i = '0;
	pmst_wb_rsp_s wb_o;
	pmst_ram_req_s ram_o;
	logic [1:0] rom_sel;
	logic [3:0] rom_addr, opt_led;
	logic [15:0] rom_data, ram_rdata;
	logic [7:0] diagnostic_result_query_led, disp_msg;
	logic [31:0] q;
	int n_errors = 0, comparisons = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	pmst_self_test #(.ROM_AW(4), .OPT_STEP(4)) pmst_self_test_inst (.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i), .wb_i(wb_i), .wb_o(wb_o), .rom_sel_o(rom_sel),
		.rom_addr_o(rom_addr), .rom_re_o(rom_re), .rom_data_i(rom_data), .ram_o(ram_o),
		.ram_rdata_i(ram_rdata), .dip_pup_i(pup), .dip_kloop_i(kloop), .diagnostic_result_query_led_o(diagnostic_result_query_led),
		.opt_led_o(opt_led), .srq_o(srq), .disp_idx_i(disp_idx), .disp_msg_o(disp_msg));
	pmst_mem_model #(.AW(4)) pmst_mem_model_inst (.clk_sys_i(clk_sys_i), .rom_sel_i(rom_sel),
		.rom_addr_i(rom_addr), .rom_re_i(rom_re), .rom_data_o(rom_data), .ram_i(ram_o),
		.fault_i(fault), .ram_rdata_o(ram_rdata));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wb_i <= '{1'b1, 1'b1, w, a, 4'hF, d};
		do @(posedge clk_sys_i); while (wb_o.ack !== 1'b1);
		q = wb_o.dat;
		wb_i <= '0;
	endtask
	task automatic wait_idle;
		repeat (10) @(posedge clk_sys_i);
		do bus(1'b0, REG_STATUS, 0); while (q[SB_BUSY] !== 1'b0);
	endtask
	task automatic boot(input logic p);
		pup <= p;
		reset_n_i <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		wait_idle;
	endtask
	task automatic t_powerup;
		boot(1'b1);
		chk("status", q & 32'h27, 32'h02);
		bus(1'b0, REG_RESULT, 0);
		chk("result", q, 32'h0);
		chk("opt_led", opt_led, OPT_ALL);
		chk("disp_first", disp_msg, 32'h0B);
	endtask
	task automatic t_checksum;
		bus(1'b1, REG_TESTNUM, 32'h6);
		bus(1'b1, REG_CTRL, 32'hC9);
		wait_idle;
		bus(1'b0, REG_RESULT, 0);
		chk("sum_result", q, 32'h0600);
	endtask
	task automatic t_fault;
		fault <= 1'b1;
		bus(1'b1, REG_TESTNUM, 32'hA);
		bus(1'b1, REG_CTRL, 32'hE9);
		repeat (100) @(posedge clk_sys_i);
		chk("probe_addr", ram_o.addr, 32'h8);
		chk("diagnostic_result_query_led", diagnostic_result_query_led, {LS_ERR, 2'b00, TC_RAM_DATA});
		fault <= 1'b0;
		bus(1'b1, REG_TESTNUM, 32'hA);
		wait_idle;
		chk("srq", srq, 1'b1);
		bus(1'b0, REG_RESULT, 0);
		chk("v_result", q, 32'h1A01);
		bus(1'b0, REG_DET_EXP, 0);
		chk("expected", q, 32'h8);
		disp_idx <= 5'h02;
		repeat (2) @(posedge clk_sys_i);
		chk("disp_fail", disp_msg, 32'h8A);
	endtask
	task automatic t_bypass;
		boot(1'b0);
		chk("byp_status", q & 32'h28, 32'h28);
		bus(1'b0, REG_RESULT, 0);
		chk("byp_result", q, 32'h2);
	endtask
	task automatic t_loop;
		bus(1'b1, REG_TESTNUM, 32'h2);
		bus(1'b1, REG_CTRL, 32'h99);
		repeat (200) @(posedge clk_sys_i);
		bus(1'b0, REG_STATUS, 0);
		chk("loop_busy", q[SB_BUSY], 1'b1);
		bus(1'b1, REG_STATUS, 0);
		wait_idle;
		chk("loop_done", q & 32'h07, 32'h02);
		bus(1'b0, REG_CTRL, 0);
		chk("loop_kept", q, 32'h98);
	endtask
	// One kernel pass is shorter than the wait, so only the switch keeps it busy
	task automatic t_kloop;
		kloop <= 1'b1;
		reset_n_i <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (12000) @(posedge clk_sys_i);
		bus(1'b0, REG_STATUS, 0);
		chk("kern_loop", q[SB_BUSY], 1'b1);
	endtask
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		t_powerup;
		t_checksum;
		t_fault;
		t_loop;
		t_kloop;
		t_bypass;
		results;
	end
	// Power-up march and the 12000-cycle kernel loop wait dominate the run
	initial begin
		#600_000;
		n_errors++;
		results;
	end
endmodule
